// *** lpb_pkg.sv ***
// Shared constants of the lane protocol bypass port.
`default_nettype none
package lpb_pkg;
  // ---------------------------------------------------------------
  // Lane geometry
  // ---------------------------------------------------------------
  localparam int LANES   = 12;
  localparam int RX_W    = 66;
  localparam int TX_W    = 64;
  localparam int SEQ_W   = 8;
  localparam int MF_W    = 4;
  localparam int RSV_W   = 2;
  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam logic [1:0] HDR_DATA      = 2'h1;
  localparam logic [1:0] HDR_CTRL      = 2'h2;
  localparam int         HDR_HI        = 65;
  localparam int         HDR_LO        = 64;
  localparam int         BLK_TYPE_HI   = 63;
  localparam int         BLK_TYPE_LO   = 58;
  localparam logic [5:0] BLK_TYPE_SYNC = 6'h1E;
  localparam int         CNT_W         = 6;
  localparam logic [5:0] SYNC_CNT_MAX  = 6'h3F;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W     = 4;
  localparam int         DATA_W     = 32;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_ALIGN  = 4'h8;
  localparam logic [3:0] REG_OVFL   = 4'hC;
  localparam int         EV_W       = 4;
  localparam int         EV_OVFL    = 0;
  localparam int         EV_BADF    = 1;
  localparam int         EV_SYNC    = 2;
  localparam int         EV_RESYNC  = 3;
  localparam logic [3:0] MASK_RST   = 4'h0;
endpackage
`default_nettype wire

// *** lpb_bypass_if.sv ***
// Interface joining the lane core end and the user fabric end.
`default_nettype none
interface lpb_bypass_if;
  // Receive path.
  logic [lpb_pkg::LANES-1:0][lpb_pkg::RX_W-1:0] rx_lane_word_out;
  logic [lpb_pkg::LANES-1:0]                    rx_lane_word_valid;
  logic [lpb_pkg::LANES-1:0]                    rx_lane_bad_framing;
  logic [lpb_pkg::LANES-1:0]                    rx_lane_framing_word;
  logic [lpb_pkg::LANES-1:0]                    rx_lane_buffer_overflow;
  logic [lpb_pkg::LANES-1:0]                    rx_lane_align_ready;
  logic [lpb_pkg::LANES-1:0]                    rx_lane_word_available;
  logic                                         rx_lane_read_request;
  logic                                         rx_force_resync;
  // Transmit path.
  logic                                         tx_lane_inputs_valid;
  logic [lpb_pkg::LANES-1:0]                    tx_lane_control_marker;
  logic [lpb_pkg::LANES-1:0][lpb_pkg::TX_W-1:0] tx_lane_word_in;
  logic [lpb_pkg::SEQ_W-1:0]                    tx_gearbox_sequence;
  logic [lpb_pkg::MF_W-1:0]                     tx_metaframe_state;
  logic [lpb_pkg::RSV_W-1:0]                    tx_reserved_ctl;

  modport core (
    output rx_lane_word_out, rx_lane_word_valid, rx_lane_bad_framing,
           rx_lane_framing_word, rx_lane_buffer_overflow,
           rx_lane_align_ready, rx_lane_word_available,
    input  rx_lane_read_request, rx_force_resync, tx_lane_inputs_valid,
           tx_lane_control_marker, tx_lane_word_in, tx_gearbox_sequence,
           tx_metaframe_state, tx_reserved_ctl
  );
  modport user (
    input  rx_lane_word_out, rx_lane_word_valid, rx_lane_bad_framing,
           rx_lane_framing_word, rx_lane_buffer_overflow,
           rx_lane_align_ready, rx_lane_word_available,
    output rx_lane_read_request, rx_force_resync, tx_lane_inputs_valid,
           tx_lane_control_marker, tx_lane_word_in, tx_gearbox_sequence,
           tx_metaframe_state, tx_reserved_ctl
  );
endinterface
`default_nettype wire

// *** lpb_user_end.sv ***
// User fabric end of the lane protocol bypass port.
`default_nettype none
module lpb_user_end #(
  parameter int LANES = lpb_pkg::LANES
) (
  // Clock and reset.
  input  wire logic                                     REF_CLK_I,
  input  wire logic                                     SRST_I,
  // Bypass port.
  lpb_bypass_if.user                                    BUS,
  // Transmit side from user logic.
  input  wire logic                                     TX_VALID_I,
  input  wire logic [LANES-1:0]                         TX_CTRL_I,
  input  wire logic [LANES-1:0][lpb_pkg::TX_W-1:0]      TX_WORD_I,
  input  wire logic [lpb_pkg::SEQ_W-1:0]                TX_SEQ_I,
  input  wire logic [lpb_pkg::MF_W-1:0]                 TX_MF_STATE_I,
  // Receive control from user logic.
  input  wire logic                                     RX_READ_EN_I,
  input  wire logic                                     RX_RESYNC_I,
  // Receive results to user logic.
  output logic      [LANES-1:0][lpb_pkg::RX_W-1:0]      RX_WORD_O,
  output logic      [LANES-1:0]                         RX_VALID_O,
  output logic      [LANES-1:0]                         RX_BAD_O,
  output logic      [LANES-1:0]                         RX_SYNC_WORD_O,
  output logic      [LANES-1:0]                         RX_OVFL_O,
  output logic      [LANES-1:0]                         RX_READY_O
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                                tx_valid;
    logic [LANES-1:0]                    tx_ctrl;
    logic [LANES-1:0][lpb_pkg::TX_W-1:0] tx_word;
    logic [lpb_pkg::SEQ_W-1:0]           tx_seq;
    logic [lpb_pkg::MF_W-1:0]            tx_mf;
    logic                                rd_req;
    logic                                resync;
    logic [LANES-1:0][lpb_pkg::RX_W-1:0] rx_word;
    logic [LANES-1:0]                    rx_valid;
    logic [LANES-1:0]                    rx_bad;
    logic [LANES-1:0]                    rx_sync;
    logic [LANES-1:0]                    rx_ovfl;
    logic [LANES-1:0]                    rx_ready;
  } lpb_user_st_t;

  lpb_user_st_t st_r;
  lpb_user_st_t st_nxt;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.tx_valid = TX_VALID_I;                          // [RQ7]
    if (TX_VALID_I) begin
      st_nxt.tx_ctrl = TX_CTRL_I;                          // [RQ8]
      st_nxt.tx_word = TX_WORD_I;                          // [RQ9]
      st_nxt.tx_seq  = TX_SEQ_I;                           // [RQ10]
      st_nxt.tx_mf   = TX_MF_STATE_I;                      // [RQ11]
    end
    st_nxt.rd_req   = RX_READ_EN_I & (|BUS.rx_lane_word_available); // [RQ12]
    st_nxt.resync   = RX_RESYNC_I;                         // [RQ14]
    st_nxt.rx_valid = BUS.rx_lane_word_valid;
    for (int i = 0; i < LANES; i++) begin
      if (BUS.rx_lane_word_valid[i]) begin
        st_nxt.rx_word[i] = BUS.rx_lane_word_out[i];
      end
    end
    st_nxt.rx_bad   = BUS.rx_lane_bad_framing & BUS.rx_lane_word_valid;
    st_nxt.rx_sync  = BUS.rx_lane_framing_word & BUS.rx_lane_word_valid;
    st_nxt.rx_ovfl  = BUS.rx_lane_buffer_overflow;
    st_nxt.rx_ready = BUS.rx_lane_align_ready;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign BUS.tx_lane_inputs_valid   = st_r.tx_valid;
  assign BUS.tx_lane_control_marker = st_r.tx_ctrl;
  assign BUS.tx_lane_word_in        = st_r.tx_word;
  assign BUS.tx_gearbox_sequence    = st_r.tx_seq;
  assign BUS.tx_metaframe_state     = st_r.tx_mf;
  assign BUS.tx_reserved_ctl        = '0;                  // [RQ15]
  assign BUS.rx_lane_read_request   = st_r.rd_req;
  assign BUS.rx_force_resync        = st_r.resync;
  assign RX_WORD_O      = st_r.rx_word;
  assign RX_VALID_O     = st_r.rx_valid;
  assign RX_BAD_O       = st_r.rx_bad;
  assign RX_SYNC_WORD_O = st_r.rx_sync;
  assign RX_OVFL_O      = st_r.rx_ovfl;
  assign RX_READY_O     = st_r.rx_ready;
endmodule
`default_nettype wire

// *** lpb_core_end.sv ***
// Lane core end of the lane protocol bypass port.
//
// Operation
// (RQ1) Twelve separate 66-bit receive word outputs.
// (RQ2) Receive word meaningful only while qualified.
// (RQ3) Flag badly framed words, not metaframe words.
// (RQ4) Flag metaframe synchronization words.
// (RQ5) Per-lane flag shows receive buffer overflow.
// (RQ6) Per-lane flag set when ready for alignment.
// (RQ7) Transmit inputs taken only in qualified cycles.
// (RQ8) User marks each lane word data or control.
// (RQ9) User supplies a 64-bit word per lane.
// (RQ10) User drives 8-bit gearbox sequence input.
// (RQ11) User drives 4-bit metaframe state input.
// (RQ12) User read request starts a receive read.
// (RQ13) Per-lane output shows a word can be read.
// (RQ14) Force resync restarts the word synchronizer.
// (RQ15) Reserved inputs held low, outputs ignored.
// (RQ16) Top two bits carry framing, low 64 payload.
//
// The address-and-strobe port and the register addresses were decided locally.
`default_nettype none
module lpb_core_end #(
  parameter int LANES = lpb_pkg::LANES
) (
  // Clock and reset.
  input  wire logic                                     REF_CLK_I,
  input  wire logic                                     SRST_I,
  // Bypass port.
  lpb_bypass_if.core                                    BUS,
  // Lane words from the receive gearbox.
  input  wire logic [LANES-1:0]                         RX_LANE_VALID_I,
  input  wire logic [LANES-1:0][lpb_pkg::RX_W-1:0]      RX_LANE_WORD_I,
  // Lane words to the transmit gearbox.
  output logic                                          TX_LANE_VALID_O,
  output logic      [LANES-1:0][lpb_pkg::RX_W-1:0]      TX_LANE_WORD_O,
  output logic      [lpb_pkg::SEQ_W-1:0]                TX_SEQ_O,
  output logic      [lpb_pkg::MF_W-1:0]                 TX_MF_STATE_O,
  // Register port.
  input  wire logic [lpb_pkg::ADDR_W-1:0]               REG_ADDR_I,
  input  wire logic [lpb_pkg::DATA_W-1:0]               REG_WDATA_I,
  input  wire logic                                     REG_WR_I,
  input  wire logic                                     REG_RD_I,
  output logic      [lpb_pkg::DATA_W-1:0]               REG_RDATA_O,
  // Interrupt.
  output logic                                          IRQ_O
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] hdr_of(
    input logic [lpb_pkg::RX_W-1:0] w
  );
    hdr_of = w[lpb_pkg::HDR_HI:lpb_pkg::HDR_LO];
  endfunction

  function automatic logic hdr_ok(input logic [lpb_pkg::RX_W-1:0] w);
    hdr_ok = (hdr_of(w) == lpb_pkg::HDR_DATA) ||
             (hdr_of(w) == lpb_pkg::HDR_CTRL);
  endfunction

  function automatic logic is_mf_sync(input logic [lpb_pkg::RX_W-1:0] w);
    is_mf_sync = (hdr_of(w) == lpb_pkg::HDR_CTRL) &&
                 (w[lpb_pkg::BLK_TYPE_HI:lpb_pkg::BLK_TYPE_LO] ==
                  lpb_pkg::BLK_TYPE_SYNC);
  endfunction

  function automatic logic [lpb_pkg::DATA_W-1:0] zext(
    input logic [LANES-1:0] v
  );
    zext = '0;
    zext[LANES-1:0] = v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [LANES-1:0][lpb_pkg::RX_W-1:0]  hold;
    logic [LANES-1:0]                     avail;
    logic [LANES-1:0][lpb_pkg::RX_W-1:0]  out_word;
    logic [LANES-1:0]                     out_valid;
    logic [LANES-1:0]                     out_bad;
    logic [LANES-1:0]                     out_sync;
    logic [LANES-1:0]                     ovfl;
    logic [LANES-1:0]                     ready;
    logic [LANES-1:0][lpb_pkg::CNT_W-1:0] cnt;
    logic                                 tx_valid;
    logic [LANES-1:0][lpb_pkg::RX_W-1:0]  tx_word;
    logic [lpb_pkg::SEQ_W-1:0]            tx_seq;
    logic [lpb_pkg::MF_W-1:0]             tx_mf;
    logic [lpb_pkg::EV_W-1:0]             status;
    logic [lpb_pkg::EV_W-1:0]             mask;
    logic [lpb_pkg::DATA_W-1:0]           rdata;
    logic                                 irq;
  } lpb_core_st_t;

  lpb_core_st_t             st_r;
  lpb_core_st_t             st_nxt;
  logic [lpb_pkg::EV_W-1:0] ev;

  function automatic lpb_core_st_t st_reset();
    st_reset      = '0;
    st_reset.mask = lpb_pkg::MASK_RST;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    ev               = '0;
    st_nxt.out_valid = '0;
    st_nxt.out_bad   = '0;
    st_nxt.out_sync  = '0;
    for (int i = 0; i < LANES; i++) begin
      // Hand a held word to the user on a read request.
      if (BUS.rx_lane_read_request && st_r.avail[i]) begin     // [RQ12]
        st_nxt.out_word[i]  = st_r.hold[i];                    // [RQ1]
        st_nxt.out_valid[i] = 1'b1;                            // [RQ2]
        st_nxt.out_sync[i]  = is_mf_sync(st_r.hold[i]);        // [RQ4]
        st_nxt.out_bad[i]   = !hdr_ok(st_r.hold[i]);           // [RQ3]
        st_nxt.avail[i]     = 1'b0;
        if (!hdr_ok(st_r.hold[i])) begin
          ev[lpb_pkg::EV_BADF] = 1'b1;
        end
      end
      // Capture arriving words; an unread word is overwritten.
      if (RX_LANE_VALID_I[i]) begin
        if (st_r.avail[i] && !BUS.rx_lane_read_request) begin
          st_nxt.ovfl[i]       = 1'b1;                         // [RQ5]
          ev[lpb_pkg::EV_OVFL] = 1'b1;
        end
        st_nxt.hold[i]  = RX_LANE_WORD_I[i];                   // [RQ16]
        st_nxt.avail[i] = 1'b1;                                // [RQ13]
        // Word lock after a run of valid framing headers.
        if (!hdr_ok(RX_LANE_WORD_I[i])) begin
          st_nxt.cnt[i]   = '0;
          st_nxt.ready[i] = 1'b0;
        end else if (st_r.cnt[i] != lpb_pkg::SYNC_CNT_MAX) begin
          st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
        end else if (!st_r.ready[i]) begin
          st_nxt.ready[i]      = 1'b1;                         // [RQ6]
          ev[lpb_pkg::EV_SYNC] = 1'b1;
        end
      end
    end
    // Restart the synchronizer of every lane.
    if (BUS.rx_force_resync) begin                             // [RQ14]
      st_nxt.cnt             = '0;
      st_nxt.ready           = '0;
      st_nxt.avail           = '0;
      st_nxt.ovfl            = '0;
      ev[lpb_pkg::EV_RESYNC] = 1'b1;
    end
    // Transmit words are taken only in qualified cycles.
    st_nxt.tx_valid = BUS.tx_lane_inputs_valid;                // [RQ7]
    if (BUS.tx_lane_inputs_valid) begin
      for (int i = 0; i < LANES; i++) begin
        st_nxt.tx_word[i] = {BUS.tx_lane_control_marker[i] ?   // [RQ8]
                             lpb_pkg::HDR_CTRL : lpb_pkg::HDR_DATA,
                             BUS.tx_lane_word_in[i]};          // [RQ9]
      end
      st_nxt.tx_seq = BUS.tx_gearbox_sequence;                 // [RQ10]
      st_nxt.tx_mf  = BUS.tx_metaframe_state;                  // [RQ11]
    end
    // Register port; status clears on read, new events win.
    st_nxt.rdata = '0;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        lpb_pkg::REG_STATUS: begin
          st_nxt.rdata[lpb_pkg::EV_W-1:0] = st_r.status;
          st_nxt.status                   = '0;
        end
        lpb_pkg::REG_MASK:  st_nxt.rdata[lpb_pkg::EV_W-1:0] = st_r.mask;
        lpb_pkg::REG_ALIGN: st_nxt.rdata = zext(st_r.ready);
        lpb_pkg::REG_OVFL:  st_nxt.rdata = zext(st_r.ovfl);
        default:            st_nxt.rdata = '0;
      endcase
    end
    if (REG_WR_I && (REG_ADDR_I == lpb_pkg::REG_MASK)) begin
      st_nxt.mask = REG_WDATA_I[lpb_pkg::EV_W-1:0];
    end
    st_nxt.status = st_nxt.status | ev;
    st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      st_r <= st_reset();
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign BUS.rx_lane_word_out        = st_r.out_word;
  assign BUS.rx_lane_word_valid      = st_r.out_valid;
  assign BUS.rx_lane_bad_framing     = st_r.out_bad;
  assign BUS.rx_lane_framing_word    = st_r.out_sync;
  assign BUS.rx_lane_buffer_overflow = st_r.ovfl;
  assign BUS.rx_lane_align_ready     = st_r.ready;
  assign BUS.rx_lane_word_available  = st_r.avail;
  assign TX_LANE_VALID_O = st_r.tx_valid;
  assign TX_LANE_WORD_O  = st_r.tx_word;
  assign TX_SEQ_O        = st_r.tx_seq;
  assign TX_MF_STATE_O   = st_r.tx_mf;
  assign REG_RDATA_O     = st_r.rdata;
  assign IRQ_O           = st_r.irq;
endmodule
`default_nettype wire

// *** lpb_sva.sv ***
// Checker of the signals that join the two ends of the bypass port.
`default_nettype none
module lpb_sva (
  // Clock and reset.
  input wire logic                                         REF_CLK_I,
  input wire logic                                         SRST_I,
  // Receive path.
  input wire logic [lpb_pkg::LANES-1:0][lpb_pkg::RX_W-1:0] rx_lane_word_out,
  input wire logic [lpb_pkg::LANES-1:0]                    rx_lane_word_valid,
  input wire logic [lpb_pkg::LANES-1:0]                    rx_lane_bad_framing,
  input wire logic [lpb_pkg::LANES-1:0]                   rx_lane_framing_word,
  input wire logic [lpb_pkg::LANES-1:0]                rx_lane_buffer_overflow,
  input wire logic [lpb_pkg::LANES-1:0]                    rx_lane_align_ready,
  input wire logic [lpb_pkg::LANES-1:0]                 rx_lane_word_available,
  input wire logic                                         rx_lane_read_request,
  input wire logic                                         rx_force_resync,
  // Transmit path.
  input wire logic [lpb_pkg::RSV_W-1:0]                    tx_reserved_ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [lpb_pkg::LANES-1:0] hdr_bad;
  logic [lpb_pkg::LANES-1:0] sync_calc;
  logic [6:0]                cnt_r;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  // Expected flags from the header and block type of each held word.
  always_comb begin
    for (int i = 0; i < lpb_pkg::LANES; i++) begin
      hdr_bad[i] = rx_lane_word_out[i][65:64] != lpb_pkg::HDR_DATA &&
                   rx_lane_word_out[i][65:64] != lpb_pkg::HDR_CTRL;
      sync_calc[i] = rx_lane_word_out[i][65:64] == lpb_pkg::HDR_CTRL &&
                     rx_lane_word_out[i][63:58] == lpb_pkg::BLK_TYPE_SYNC;
    end
  end

  // Cycles since reset or resync, saturating.
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || rx_force_resync) begin
      cnt_r <= 7'h00;
    end else if (cnt_r != 7'h7F) begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  a_bad_header: assert property (
    rx_lane_bad_framing == (rx_lane_word_valid & hdr_bad))
    else $error("bad framing flag wrong");
  a_sync_word: assert property (
    rx_lane_framing_word == (rx_lane_word_valid & sync_calc))
    else $error("framing word flag wrong");
  a_read_valid: assert property (
    rx_lane_word_valid == ($past(rx_lane_word_available) &
      {lpb_pkg::LANES{$past(rx_lane_read_request)}}))
    else $error("word valid not tied to read of available lanes");
  a_ovfl_sticky: assert property (
    !$past(rx_force_resync) |-> (($past(rx_lane_buffer_overflow) &
      ~rx_lane_buffer_overflow) == 12'h000))
    else $error("overflow flag dropped without resync");
  a_resync_ready: assert property (
    rx_force_resync |=> rx_lane_align_ready == 12'h000)
    else $error("align ready kept over resync");
  a_word_holds: assert property (
    rx_lane_word_valid == 12'h000 |-> $stable(rx_lane_word_out))
    else $error("word output changed without valid");
  a_ready_count: assert property (
    (rx_lane_align_ready & ~$past(rx_lane_align_ready)) != 12'h000
      |-> cnt_r >= 7'h40)
    else $error("align ready too early");
  a_reserved_low: assert property (
    tx_reserved_ctl == 2'h0)
    else $error("reserved control not low");

  c_bad: cover property (rx_lane_bad_framing != 12'h000);
  c_sync: cover property (rx_lane_framing_word != 12'h000);
  c_ovfl: cover property ($rose(rx_lane_buffer_overflow[2]));
  c_ready: cover property ($rose(rx_lane_align_ready[1]));
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of both ends of the lane protocol bypass port.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic [11:0]            rx_lv = '0;
  logic [11:0][65:0]      rx_lw = '0;
  logic [11:0][65:0]      rx_word;
  logic [11:0]            rx_val, rx_bad, rx_sw, rx_ovf, rx_rdy;
  logic                   tx_v = 1'b0, tx_lv;
  logic [11:0]            tx_c = '0;
  logic [11:0][63:0]      tx_w = '0;
  logic [11:0][65:0]      tx_lw;
  logic [7:0]             tx_s = '0, tx_so;
  logic [3:0]             tx_m = '0, tx_mo;
  logic                   rd_en = 1'b1, rsync = 1'b0;
  logic [3:0]             r_addr = '0;
  logic [31:0]            r_wd = '0, r_rdata, d;
  logic                   r_wr = 1'b0, r_rd = 1'b0, irq;
  int                     n_mismatch = 0, cmp_count = 0;

  always #20 clk = ~clk;

  lpb_bypass_if i_lpb_bypass_if ();
  lpb_core_end i_lpb_core_end (.REF_CLK_I(clk), .SRST_I(srst),
    .BUS(i_lpb_bypass_if), .RX_LANE_VALID_I(rx_lv), .RX_LANE_WORD_I(rx_lw),
    .TX_LANE_VALID_O(tx_lv), .TX_LANE_WORD_O(tx_lw), .TX_SEQ_O(tx_so),
    .TX_MF_STATE_O(tx_mo), .REG_ADDR_I(r_addr), .REG_WDATA_I(r_wd),
    .REG_WR_I(r_wr), .REG_RD_I(r_rd), .REG_RDATA_O(r_rdata), .IRQ_O(irq));
  lpb_user_end i_lpb_user_end (.REF_CLK_I(clk), .SRST_I(srst),
    .BUS(i_lpb_bypass_if), .TX_VALID_I(tx_v), .TX_CTRL_I(tx_c),
    .TX_WORD_I(tx_w), .TX_SEQ_I(tx_s), .TX_MF_STATE_I(tx_m),
    .RX_READ_EN_I(rd_en), .RX_RESYNC_I(rsync), .RX_WORD_O(rx_word),
    .RX_VALID_O(rx_val), .RX_BAD_O(rx_bad), .RX_SYNC_WORD_O(rx_sw),
    .RX_OVFL_O(rx_ovf), .RX_READY_O(rx_rdy));
  lpb_sva i_lpb_sva (.REF_CLK_I(clk), .SRST_I(srst),
    .rx_lane_word_out(i_lpb_bypass_if.rx_lane_word_out),
    .rx_lane_word_valid(i_lpb_bypass_if.rx_lane_word_valid),
    .rx_lane_bad_framing(i_lpb_bypass_if.rx_lane_bad_framing),
    .rx_lane_framing_word(i_lpb_bypass_if.rx_lane_framing_word),
    .rx_lane_buffer_overflow(i_lpb_bypass_if.rx_lane_buffer_overflow),
    .rx_lane_align_ready(i_lpb_bypass_if.rx_lane_align_ready),
    .rx_lane_word_available(i_lpb_bypass_if.rx_lane_word_available),
    .rx_lane_read_request(i_lpb_bypass_if.rx_lane_read_request),
    .rx_force_resync(i_lpb_bypass_if.rx_force_resync),
    .tx_reserved_ctl(i_lpb_bypass_if.tx_reserved_ctl));

  task automatic chk(input string nm, input logic [65:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    r_addr <= a;
    r_wd <= v;
    r_wr <= 1'b1;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    r_addr <= a;
    r_rd <= 1'b1;
    @(posedge clk);
    r_rd <= 1'b0;
    #1;
    d = r_rdata;
  endtask
  task automatic burst(input logic [11:0] m, input logic [11:0][65:0] ws,
                       input int n);
    @(posedge clk);
    rx_lw <= ws;
    rx_lv <= m;
    repeat (n) @(posedge clk);
    rx_lv <= '0;
  endtask

  // Registers after reset, an unmapped and a read-only place.
  task automatic t_regs();
    reg_wr(lpb_pkg::REG_ALIGN, 32'hFFFFFFFF);
    reg_rd(lpb_pkg::REG_MASK);
    chk("mask", 32'h0, d);
    reg_rd(lpb_pkg::REG_ALIGN);
    chk("align", 32'h0, d);
    reg_rd(4'h2);
    chk("unmapped", 32'h0, d);
  endtask
  // Data, metaframe and badly framed words read out together.
  task automatic t_rx_read();
    logic [11:0][65:0] ws;
    int                k;
    ws = '0;
    ws[0] = {lpb_pkg::HDR_DATA, 64'h0123456789ABCDEF};
    ws[3] = {lpb_pkg::HDR_CTRL, lpb_pkg::BLK_TYPE_SYNC, 58'h0};
    ws[5] = {2'h3, 64'h0};
    burst(12'h029, ws, 1);
    k = 0;
    while (rx_val === 12'h000 && k < 12) begin
      cyc(1);
      k++;
    end
    chk("rx_valid", 12'h029, rx_val);
    chk("rx_word0", ws[0], rx_word[0]);
    chk("rx_word3", ws[3], rx_word[3]);
    chk("rx_bad", 12'h020, rx_bad);
    chk("rx_sync", 12'h008, rx_sw);
  endtask
  // Overflow on an unread lane, interrupt masked, raised and cleared.
  task automatic t_overflow();
    @(posedge clk);
    rd_en <= 1'b0;
    reg_rd(lpb_pkg::REG_STATUS);
    burst(12'h004, {12{lpb_pkg::HDR_DATA, 64'h1}}, 1);
    burst(12'h004, {12{lpb_pkg::HDR_DATA, 64'h2}}, 1);
    cyc(3);
    chk("rx_ovfl", 12'h004, rx_ovf);
    chk("irq_masked", 1'b0, irq);
    reg_wr(lpb_pkg::REG_MASK, 32'h1);
    cyc(2);
    chk("irq_set", 1'b1, irq);
    reg_rd(lpb_pkg::REG_OVFL);
    chk("reg_ovfl", 32'h4, d);
    reg_rd(lpb_pkg::REG_STATUS);
    chk("status_ovfl", 1'b1, d[0]);
    cyc(2);
    chk("irq_clear", 1'b0, irq);
    @(posedge clk);
    rd_en <= 1'b1;
  endtask
  // Lock after the 64th good word, then a forced resync.
  task automatic t_lock();
    burst(12'h002, {12{lpb_pkg::HDR_DATA, 64'h5}}, 63);
    cyc(3);
    chk("ready_63", 12'h000, rx_rdy);
    burst(12'h002, {12{lpb_pkg::HDR_CTRL, 64'h7}}, 1);
    cyc(3);
    chk("ready_64", 12'h002, rx_rdy);
    reg_rd(lpb_pkg::REG_ALIGN);
    chk("reg_align", 32'h2, d);
    @(posedge clk);
    rsync <= 1'b1;
    @(posedge clk);
    rsync <= 1'b0;
    cyc(4);
    chk("ready_resync", 12'h000, rx_rdy);
    chk("ovfl_resync", 12'h000, rx_ovf);
    reg_rd(lpb_pkg::REG_STATUS);
    chk("status_resync", 2'h3, d[3:2]);
  endtask
  // Transmit taken in a qualified cycle, ignored in the next one.
  task automatic t_tx();
    @(posedge clk);
    tx_v <= 1'b1;
    tx_c <= 12'h801;
    tx_w <= {12{64'hA5A5A5A5C3C3C3C3}};
    tx_s <= 8'h5A;
    tx_m <= 4'h9;
    @(posedge clk);
    tx_v <= 1'b0;
    tx_w <= '1;
    tx_s <= 8'h00;
    cyc(1);
    chk("tx_valid", 1'b1, tx_lv);
    chk("tx_word0", {lpb_pkg::HDR_CTRL, 64'hA5A5A5A5C3C3C3C3},
        tx_lw[0]);
    chk("tx_word5", {lpb_pkg::HDR_DATA, 64'hA5A5A5A5C3C3C3C3},
        tx_lw[5]);
    chk("tx_seq", 8'h5A, tx_so);
    chk("tx_mf", 4'h9, tx_mo);
    cyc(1);
    chk("tx_idle", 1'b0, tx_lv);
    chk("tx_hold", 8'h5A, tx_so);
    chk("tx_word_hold", {lpb_pkg::HDR_CTRL, 64'hA5A5A5A5C3C3C3C3}, tx_lw[0]);
  endtask

  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_rx_read();
    t_overflow();
    t_lock();
    t_tx();
    stop_test();
  end
endmodule
`default_nettype wire
